// [scmc_pkg.sv]
// constants for the startup configuration and map control block
package scmc_pkg;
    // register bus
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 8;
    localparam logic [5:0] OFF_OPTIONS = 6'h39;
    localparam logic [5:0] OFF_PROG    = 6'h3B;
    localparam logic [5:0] OFF_MAP     = 6'h3D;
    localparam logic [5:0] OFF_CONFIG  = 6'h3F;
    // startup configuration fields
    localparam int unsigned CFG_SECURITY_DISABLE = 3;
    localparam int unsigned CFG_WATCHDOG_DISABLE = 2;
    localparam int unsigned CFG_ROM_ENABLE       = 1;
    localparam int unsigned CFG_EEPROM_ENABLE    = 0;
    // map register fields
    localparam int unsigned MAP_RAM_LSB = 4;
    localparam int unsigned MAP_REG_LSB = 0;
    localparam logic [7:0]  MAP_RESET   = 8'h01;
    // options register fields
    localparam int unsigned OPT_CONVERTER_POWER_UP = 7;
    localparam int unsigned OPT_PUMP_CLOCK_SELECT  = 6;
    localparam int unsigned OPT_INTERRUPT_EDGE     = 5;
    localparam int unsigned OPT_OSC_WAIT_SELECT    = 4;
    localparam int unsigned OPT_CLOCK_MONITOR      = 3;
    localparam int unsigned OPT_RATE_LSB           = 0;
    localparam logic [7:0]  OPT_RESET              = 8'h10;
    localparam logic [7:0]  OPT_ANYTIME_MASK       = 8'hC8;
    localparam logic [7:0]  OPT_PROTECTED_MASK     = 8'h33;
    // programming control fields
    localparam int unsigned PRG_LATCH   = 5;
    localparam int unsigned PRG_VOLTAGE = 0;
    // timing, in E-clock cycles
    localparam int unsigned PROTECT_WINDOW_CYCLES = 64;
    localparam int unsigned STOP_FAST_CYCLES      = 4;
    localparam int unsigned STOP_DELAY_CYCLES     = 4000;
    localparam int unsigned WATCHDOG_PREDIV       = 32768;
    localparam int unsigned SYNC_STAGES           = 3;
    // erased byte value
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
endpackage

// [scmc_top.sv]
// startup configuration, memory map and programming control logic
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: security disable reads 1 when no security option; else 0 secures, 1 frees.
// R2: watchdog disable bit 1 stops watchdog, 0 lets it run.
// R3: rom enable 0 removes internal rom from map, range goes external.
// R4: single-chip mode forces rom enable to 1. Code forces rom_mapped_out only; config read keeps latched bit.
// R5: eeprom enable 0 unmaps eeprom; 1 maps it.
// R6: map register places registers and ram on any 4-Kbyte page.
// R7: map register takes one write in first 64 cycles, normal modes.
// R8: ram bits give upper hex digit of ram base; reset page zero.
// R9: register bits give upper digit of 64-byte block base; reset page one.
// R10: protected options write once in 64 cycles; special modes anytime.
// R11: oscillator wait clear resumes from stop within four cycles.
// R12: oscillator wait set waits 4000 cycles before resuming from stop.
// R13: pump clock select picks charge pump and converter clock source.
// R14: pump clock select 0 uses E clock, 1 uses internal oscillator.
// R15: options bit 2 always reads 0.
// R16: watchdog uses E clock divided by 2^15, then rate scaling.
// R17: erased cells read 1; programming only clears bits.
// R18: software first writes 20 hex to set only the latch.
// R19: software stores data to eprom, then writes 21 hex.
// R20: software holds voltage 2 to 4 ms then clears control register.
// R21: system sets rom enable, applies supply, holds irq high first.
// R22: latch set makes eprom writes latch address and data; reads blocked.
// R23: voltage enable writable only while latch is 1; other writes ignored.
// R24: late or repeated writes to write-once bits are silently ignored.
// R25: startup latches load from nonvolatile copy every reset; reads return them.
module scmc_top #(
    parameter int unsigned EPROM_DEPTH     = 16,
    parameter int unsigned EPROM_ADDR_W    = 4,
    parameter bit          SECURITY_OPTION = 1'b1,
    parameter int unsigned WATCHDOG_DIV    = scmc_pkg::WATCHDOG_PREDIV
) (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    // register port
    input  wire logic [5:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    // mode pins and nonvolatile copy
    input  wire logic        special_mode_in,
    input  wire logic        single_chip_in,
    input  wire logic [3:0]  nv_config_in,
    // stop mode and oscillator
    input  wire logic        stop_exit_in,
    input  wire logic        rc_osc_in,
    output logic             resume_out,
    // map control
    output logic             rom_mapped_out,
    output logic             eeprom_mapped_out,
    output logic      [3:0]  ram_page_out,
    output logic      [3:0]  reg_page_out,
    output logic             security_on_out,
    // options
    output logic             watchdog_enable_out,
    output logic             watchdog_tick_out,
    output logic             interrupt_edge_only_out,
    output logic             converter_power_up_out,
    output logic             clock_monitor_enable_out,
    output logic             pump_clock_select_out,
    output logic             pump_clock_en_out,
    // eprom access
    input  wire logic                    eprom_wr_in,
    input  wire logic                    eprom_rd_in,
    input  wire logic [EPROM_ADDR_W-1:0] eprom_addr_in,
    input  wire logic [7:0]              eprom_wdata_in,
    output logic      [7:0]              eprom_rdata_out,
    output logic                         eprom_read_blocked_out,
    output logic                         program_voltage_out
);

    initial begin
        if (EPROM_DEPTH < 1 || EPROM_DEPTH > (1 << EPROM_ADDR_W))
            $error("scmc_top: eprom depth does not fit address width");
        if (WATCHDOG_DIV < 2)
            $error("scmc_top: watchdog divider too small");
    end

    localparam int unsigned NSYNC = 8;
    localparam int unsigned WDW = $clog2(WATCHDOG_DIV);
    localparam logic [6:0] WINDOW_END =
        7'(scmc_pkg::PROTECT_WINDOW_CYCLES);
    localparam logic [11:0] FAST_LAST =
        12'(scmc_pkg::STOP_FAST_CYCLES - 1);
    localparam logic [11:0] DELAY_LAST =
        12'(scmc_pkg::STOP_DELAY_CYCLES - 1);
    localparam logic [WDW-1:0] PREDIV_LAST = WDW'(WATCHDOG_DIV - 1);
    localparam logic [2:0] LOAD_LAST = 3'(scmc_pkg::SYNC_STAGES + 2);

    typedef enum logic [0:0] {SCMC_RUN, SCMC_WAKE} scmc_stop_t;

    // input synchronisers: change taken when stages two and three agree
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    logic [NSYNC-1:0] clean;

    assign raw_in = {nv_config_in, rc_osc_in, stop_exit_in,
                     single_chip_in, special_mode_in};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge sys_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                    clean[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= raw_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi])
                        clean[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    wire       special_mode = clean[0];
    wire       single_chip  = clean[1];
    wire       stop_exit    = clean[2];
    wire       rc_osc       = clean[3];
    wire [3:0] nv_config    = clean[7:4];

    // register state
    logic [3:0]  config_latch;
    logic [2:0]  load_cnt;
    logic [7:0]  map_reg;
    logic [7:0]  option_reg;
    logic        map_written;
    logic        option_written;
    logic [6:0]  window_cnt;
    logic        prog_latch;
    logic        prog_voltage;

    // decode
    wire wr_config  = reg_wr_in && reg_addr_in == scmc_pkg::OFF_CONFIG;
    wire wr_map     = reg_wr_in && reg_addr_in == scmc_pkg::OFF_MAP;
    wire wr_option  = reg_wr_in && reg_addr_in == scmc_pkg::OFF_OPTIONS;
    wire wr_prog    = reg_wr_in && reg_addr_in == scmc_pkg::OFF_PROG;
    wire window_open = window_cnt < WINDOW_END;
    wire map_ok     = special_mode || (window_open && !map_written);
    wire option_ok  = special_mode || (window_open && !option_written);
    wire config_loaded = load_cnt == LOAD_LAST;

    // startup latches loaded after reset once inputs have settled
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            load_cnt     <= '0;
            config_latch <= '0;
        end else if (!config_loaded) begin
            load_cnt     <= load_cnt + 3'(1);
            config_latch <= nv_config;                         // R25
        end
    end

    // protection window counter
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            window_cnt <= '0;
        else if (window_open)
            window_cnt <= window_cnt + 7'(1);
    end

    // map register, write-once in normal modes
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            map_reg     <= scmc_pkg::MAP_RESET;                // R8 R9
            map_written <= 1'b0;
        end else if (wr_map && map_ok) begin                   // R7 R24
            map_reg     <= reg_wdata_in;                       // R6
            map_written <= 1'b1;
        end
    end

    // options register, time-protected fields
    wire [7:0] option_keep_mask = option_ok ? 8'h00
                                 : scmc_pkg::OPT_PROTECTED_MASK;
    wire [7:0] next_option =
        (option_reg & option_keep_mask)
        | (reg_wdata_in & ~option_keep_mask
           & (scmc_pkg::OPT_ANYTIME_MASK | scmc_pkg::OPT_PROTECTED_MASK));

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            option_reg     <= scmc_pkg::OPT_RESET;
            option_written <= 1'b0;
        end else if (wr_option) begin
            option_reg <= next_option;                         // R10 R24 R15
            if (option_ok)
                option_written <= 1'b1;
        end
    end

    // programming control: latch then voltage
    wire wdata_latch   = reg_wdata_in[scmc_pkg::PRG_LATCH];
    wire wdata_voltage = reg_wdata_in[scmc_pkg::PRG_VOLTAGE];
    wire next_latch    = (prog_voltage && wdata_voltage) ? prog_latch
                                                         : wdata_latch;
    wire next_voltage  = prog_latch ? wdata_voltage : prog_voltage;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prog_latch   <= 1'b0;
            prog_voltage <= 1'b0;
        end else if (wr_prog) begin
            prog_latch   <= next_latch;                        // R18 R20
            prog_voltage <= next_voltage;                      // R23 R19
        end
    end

    // eprom cells, latched address and data
    logic [7:0]              eprom_mem [EPROM_DEPTH];
    logic [EPROM_ADDR_W-1:0] lat_addr;
    logic [7:0]              lat_data;
    logic                    lat_valid;
    wire  eprom_latch_wr = prog_latch && eprom_wr_in && !prog_voltage;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lat_addr  <= '0;
            lat_data  <= scmc_pkg::ERASED_BYTE;
            lat_valid <= 1'b0;
        end else if (eprom_latch_wr) begin                     // R22
            lat_addr  <= eprom_addr_in;
            lat_data  <= eprom_wdata_in;
            lat_valid <= 1'b1;
        end else if (!prog_latch) begin
            lat_valid <= 1'b0;
        end
    end

    wire burn = prog_voltage && lat_valid;

    generate
        for (gi = 0; gi < EPROM_DEPTH; gi++) begin : g_cell
            always_ff @(posedge sys_clk_in or negedge rstn_in) begin
                if (!rstn_in)
                    eprom_mem[gi] <= scmc_pkg::ERASED_BYTE;    // R17
                else if (burn && lat_addr == EPROM_ADDR_W'(gi))
                    eprom_mem[gi] <= eprom_mem[gi] & lat_data; // R17
            end
        end
    endgenerate

    wire [7:0] eprom_sel = eprom_mem[eprom_addr_in];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            eprom_rdata_out <= scmc_pkg::ERASED_BYTE;
        else if (eprom_rd_in)
            eprom_rdata_out <= prog_latch ? scmc_pkg::ERASED_BYTE
                                          : eprom_sel;         // R22
    end

    // register read
    wire       sec_bit = SECURITY_OPTION
                         ? config_latch[scmc_pkg::CFG_SECURITY_DISABLE]
                         : 1'b1;                               // R1
    wire [7:0] config_view = {4'h0, sec_bit, config_latch[2:0]};
    wire [7:0] prog_view   = 8'(({7'h00, prog_latch} << scmc_pkg::PRG_LATCH)
                           | ({7'h00, prog_voltage} << scmc_pkg::PRG_VOLTAGE));
    wire [7:0] read_mux =
        reg_addr_in == scmc_pkg::OFF_CONFIG  ? config_view :
        reg_addr_in == scmc_pkg::OFF_MAP     ? map_reg :
        reg_addr_in == scmc_pkg::OFF_OPTIONS ? option_reg :
        reg_addr_in == scmc_pkg::OFF_PROG    ? prog_view : 8'h00;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in)
            reg_rdata_out <= read_mux;                         // R25
        else
            reg_rdata_out <= 8'h00;
    end

    // stop-mode exit timing
    scmc_stop_t stop_state;
    logic [11:0] wake_cnt;
    logic        stop_exit_d;
    wire  stop_rise = stop_exit && !stop_exit_d;
    wire  osc_wait  = option_reg[scmc_pkg::OPT_OSC_WAIT_SELECT];
    wire [11:0] wake_last = osc_wait ? DELAY_LAST : FAST_LAST; // R11 R12

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stop_state  <= SCMC_RUN;
            wake_cnt    <= '0;
            stop_exit_d <= 1'b0;
            resume_out  <= 1'b0;
        end else begin
            stop_exit_d <= stop_exit;
            resume_out  <= 1'b0;
            unique case (stop_state)
                SCMC_RUN: begin
                    wake_cnt <= '0;
                    if (stop_rise)
                        stop_state <= SCMC_WAKE;
                end
                SCMC_WAKE: begin
                    wake_cnt <= wake_cnt + 12'(1);
                    if (wake_cnt >= wake_last) begin           // R11 R12
                        stop_state <= SCMC_RUN;
                        resume_out <= 1'b1;
                    end
                end
            endcase
        end
    end

    // watchdog prescaler and rate scaling
    logic [WDW-1:0] prediv_cnt;
    logic [5:0]     rate_cnt;
    wire  watchdog_on = !config_latch[scmc_pkg::CFG_WATCHDOG_DISABLE]
                        && config_loaded;                      // R2
    wire [1:0] rate_sel = option_reg[scmc_pkg::OPT_RATE_LSB +: 2];
    wire [5:0] rate_last = 6'((7'h01 << {rate_sel, 1'b0}) - 7'h01);
    wire       prediv_tick = prediv_cnt == PREDIV_LAST;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prediv_cnt        <= '0;
            rate_cnt          <= '0;
            watchdog_tick_out <= 1'b0;
        end else begin
            watchdog_tick_out <= 1'b0;
            if (!watchdog_on) begin
                prediv_cnt <= '0;
                rate_cnt   <= '0;
            end else if (prediv_tick) begin                    // R16
                prediv_cnt <= '0;
                if (rate_cnt >= rate_last) begin               // R16
                    rate_cnt          <= '0;
                    watchdog_tick_out <= 1'b1;
                end else begin
                    rate_cnt <= rate_cnt + 6'(1);
                end
            end else begin
                prediv_cnt <= prediv_cnt + WDW'(1);
            end
        end
    end

    // charge pump and converter clock enable
    logic rc_osc_d;
    wire  pump_sel = option_reg[scmc_pkg::OPT_PUMP_CLOCK_SELECT];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            rc_osc_d <= 1'b0;
        else
            rc_osc_d <= rc_osc;
    end

    assign pump_clock_select_out = pump_sel;                   // R13
    assign pump_clock_en_out = pump_sel ? (rc_osc && !rc_osc_d)
                                        : 1'b1;                // R14

    // map and option outputs
    assign rom_mapped_out = config_latch[scmc_pkg::CFG_ROM_ENABLE]
                            || single_chip;                    // R3 R4
    assign eeprom_mapped_out =
        config_latch[scmc_pkg::CFG_EEPROM_ENABLE];             // R5
    assign ram_page_out = map_reg[scmc_pkg::MAP_RAM_LSB +: 4];  // R8
    assign reg_page_out = map_reg[scmc_pkg::MAP_REG_LSB +: 4];  // R9
    assign security_on_out = !sec_bit;                         // R1
    assign watchdog_enable_out = watchdog_on;                  // R2
    assign interrupt_edge_only_out =
        option_reg[scmc_pkg::OPT_INTERRUPT_EDGE];
    assign converter_power_up_out =
        option_reg[scmc_pkg::OPT_CONVERTER_POWER_UP];
    assign clock_monitor_enable_out =
        option_reg[scmc_pkg::OPT_CLOCK_MONITOR];
    assign eprom_read_blocked_out = prog_latch;                // R22
    assign program_voltage_out = prog_voltage;

    wire unused_ok = wr_config;

endmodule

`default_nettype wire

// [scmc_top_sva.sv]
// assertion checker for the configuration and map control block
`timescale 1ns/1ps
`default_nettype none
module scmc_top_sva (
    // clock and reset
    input wire logic       sys_clk_in,
    input wire logic       rstn_in,
    // register port
    input wire logic [5:0] reg_addr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // map and options
    input wire logic       security_on_out,
    input wire logic       watchdog_enable_out,
    input wire logic       eeprom_mapped_out,
    input wire logic [3:0] ram_page_out,
    input wire logic [3:0] reg_page_out,
    input wire logic       pump_clock_select_out,
    input wire logic       pump_clock_en_out,
    input wire logic       resume_out,
    // eprom access
    input wire logic       eprom_rd_in,
    input wire logic [7:0] eprom_rdata_out,
    input wire logic       eprom_read_blocked_out,
    input wire logic       program_voltage_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    property p_rdata_idle;
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read answer");
    property p_opt_bit2;
        $past(reg_rd_in) && $past(reg_addr_in) == scmc_pkg::OFF_OPTIONS
            |-> !reg_rdata_out[2];
    endproperty
    a_opt_bit2: assert property (p_opt_bit2)
        else $error("options bit 2 read as one");
    property p_map_read;
        $past(reg_rd_in) && $past(reg_addr_in) == scmc_pkg::OFF_MAP
            |-> reg_rdata_out == {ram_page_out, reg_page_out};
    endproperty
    a_map_read: assert property (p_map_read)
        else $error("map read differs from page outputs");
    property p_cfg_read;
        $past(reg_rd_in) && $past(reg_addr_in) == scmc_pkg::OFF_CONFIG
            |-> reg_rdata_out[3] == !security_on_out
            && reg_rdata_out[2] == !watchdog_enable_out
            && reg_rdata_out[0] == eeprom_mapped_out;
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config read differs from control outputs");
    property p_pump;
        !pump_clock_select_out && !$past(pump_clock_select_out)
            |-> pump_clock_en_out;
    endproperty
    a_pump: assert property (p_pump)
        else $error("pump clock not on e clock with select low");
    property p_volt_rise;
        $rose(program_voltage_out) |-> $past(eprom_read_blocked_out);
    endproperty
    a_volt_rise: assert property (p_volt_rise)
        else $error("voltage set without latch");
    property p_blocked_read;
        $past(eprom_rd_in) && $past(eprom_read_blocked_out)
            |-> eprom_rdata_out == scmc_pkg::ERASED_BYTE;
    endproperty
    a_blocked_read: assert property (p_blocked_read)
        else $error("eprom read not blocked while latched");
    property p_resume_pulse;
        resume_out |=> !resume_out;
    endproperty
    a_resume_pulse: assert property (p_resume_pulse)
        else $error("resume longer than one cycle");
endmodule

bind scmc_top scmc_top_sva scmc_top_sva_inst (
    .sys_clk_in, .rstn_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out,
    .security_on_out, .watchdog_enable_out, .eeprom_mapped_out,
    .ram_page_out, .reg_page_out, .pump_clock_select_out,
    .pump_clock_en_out, .resume_out, .eprom_rd_in, .eprom_rdata_out,
    .eprom_read_blocked_out, .program_voltage_out
);
`default_nettype wire

// [system_config_and_map_control_test.sv]
// self-checking testbench for the configuration and map control block
`timescale 1ns/1ps
`default_nettype none
module system_config_and_map_control_test;
    logic       sys_clk_in, rstn_in, wr, rd, spec, single, stop, rc, ewr, erd;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, ewdata, erdata, d;
    logic [3:0] nv, eaddr, ram_pg, reg_pg, opt_o;
    logic       resume, rom_m, ee_m, sec, wd_en, tick, blocked, volt;
    int         miscompares = 0;
    int         samples_checked = 0;
    int         n;

    scmc_top #(.WATCHDOG_DIV(8)) scmc_top_inst (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .special_mode_in(spec),
        .single_chip_in(single), .nv_config_in(nv), .stop_exit_in(stop),
        .rc_osc_in(rc), .resume_out(resume), .rom_mapped_out(rom_m),
        .eeprom_mapped_out(ee_m), .ram_page_out(ram_pg),
        .reg_page_out(reg_pg), .security_on_out(sec),
        .watchdog_enable_out(wd_en), .watchdog_tick_out(tick),
        .interrupt_edge_only_out(opt_o[1]),
        .converter_power_up_out(opt_o[3]),
        .clock_monitor_enable_out(opt_o[0]),
        .pump_clock_select_out(opt_o[2]),
        .pump_clock_en_out(), .eprom_wr_in(ewr), .eprom_rd_in(erd),
        .eprom_addr_in(eaddr), .eprom_wdata_in(ewdata),
        .eprom_rdata_out(erdata), .eprom_read_blocked_out(blocked),
        .program_voltage_out(volt)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) rc <= ~rc;

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic rst;
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        repeat (12) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic wreg(input logic [5:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rreg(input string nm, input logic [5:0] a,
                        input logic [7:0] m, exp);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        chk(nm, rdata & m, exp);
    endtask
    task automatic rep(input string nm, input logic [3:0] a,
                       input logic [7:0] exp);
        @(posedge sys_clk_in);
        eaddr <= a;
        erd <= 1'b1;
        @(posedge sys_clk_in);
        erd <= 1'b0;
        #1;
        chk(nm, erdata, exp);
    endtask
    task automatic wait_sig(input bit res, input int lim);
        n = 0;
        do begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end while (!(res ? resume : tick) && n < lim);
        if (!(res ? resume : tick)) begin
            miscompares++;
            complete_run();
        end
    endtask

    initial begin
        rstn_in = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        spec = 1'b0;
        single = 1'b0;
        stop = 1'b0;
        rc = 1'b0;
        ewr = 1'b0;
        erd = 1'b0;
        addr = 6'h00;
        wdata = 8'h00;
        ewdata = 8'h00;
        eaddr = 4'h0;
        nv = 4'hA;
        rst();
        rreg("config", scmc_pkg::OFF_CONFIG, 8'h0F, 8'h0A);
        rreg("options", scmc_pkg::OFF_OPTIONS, 8'hFF, 8'h10);
        rreg("map", scmc_pkg::OFF_MAP, 8'hFF, 8'h01);
        chk("sec", {7'h00, sec}, 8'h00);
        chk("wd", {7'h00, wd_en}, 8'h01);
        chk("ee", {7'h00, ee_m}, 8'h00);
        chk("rom", {7'h00, rom_m}, 8'h01);
        wait_sig(1'b0, 40);
        wait_sig(1'b0, 40);
        chk("tick rate 0", n[7:0], 8'h08);
        $display("test reset values done");
        wreg(scmc_pkg::OFF_MAP, 8'hA2);
        wreg(scmc_pkg::OFF_MAP, 8'h55);
        rreg("map once", scmc_pkg::OFF_MAP, 8'hFF, 8'hA2);
        chk("ram page", {4'h0, ram_pg}, 8'h0A);
        chk("reg page", {4'h0, reg_pg}, 8'h02);
        wreg(scmc_pkg::OFF_OPTIONS, 8'hFF);
        rreg("opt ff", scmc_pkg::OFF_OPTIONS, 8'hFF, 8'hFB);
        chk("opt pins", {4'h0, opt_o}, 8'h0F);
        wreg(scmc_pkg::OFF_OPTIONS, 8'h00);
        rreg("opt 00", scmc_pkg::OFF_OPTIONS, 8'hFF, 8'h33);
        chk("opt pins 00", {4'h0, opt_o}, 8'h02);
        wait_sig(1'b0, 600);
        wait_sig(1'b0, 600);
        chk("tick rate 3", n[15:8], 8'h02);
        $display("test window writes done");
        rst();
        repeat (70) @(posedge sys_clk_in);
        wreg(scmc_pkg::OFF_MAP, 8'h5C);
        rreg("map late", scmc_pkg::OFF_MAP, 8'hFF, 8'h01);
        wreg(scmc_pkg::OFF_OPTIONS, 8'h03);
        rreg("opt late", scmc_pkg::OFF_OPTIONS, 8'hFF, 8'h10);
        stop <= 1'b1;
        wait_sig(1'b1, 4100);
        chk("slow wake", 8'(n >= 4000 && n <= 4008), 8'h01);
        stop <= 1'b0;
        $display("test late writes done");
        spec <= 1'b1;
        rst();
        repeat (70) @(posedge sys_clk_in);
        wreg(scmc_pkg::OFF_OPTIONS, 8'h03);
        rreg("opt special", scmc_pkg::OFF_OPTIONS, 8'hFF, 8'h03);
        wreg(scmc_pkg::OFF_MAP, 8'h5C);
        rreg("map special", scmc_pkg::OFF_MAP, 8'hFF, 8'h5C);
        stop <= 1'b1;
        wait_sig(1'b1, 40);
        chk("fast wake", 8'(n >= 4 && n <= 9), 8'h01);
        stop <= 1'b0;
        spec <= 1'b0;
        $display("test special mode done");
        nv <= 4'h5;
        rst();
        chk("sec on", {7'h00, sec}, 8'h01);
        chk("wd off", {7'h00, wd_en}, 8'h00);
        chk("ee on", {7'h00, ee_m}, 8'h01);
        chk("rom off", {7'h00, rom_m}, 8'h00);
        single <= 1'b1;
        repeat (6) @(posedge sys_clk_in);
        chk("rom forced", {7'h00, rom_m}, 8'h01);
        wreg(scmc_pkg::OFF_CONFIG, 8'h00);
        rreg("config ro", scmc_pkg::OFF_CONFIG, 8'h0F, 8'h05);
        $display("test config done");
        wreg(scmc_pkg::OFF_PROG, 8'h01);
        rreg("volt no latch", scmc_pkg::OFF_PROG, 8'hFF, 8'h00);
        wreg(scmc_pkg::OFF_PROG, 8'h20);
        rreg("latch", scmc_pkg::OFF_PROG, 8'hFF, 8'h20);
        rep("blocked read", 4'h3, 8'hFF);
        @(posedge sys_clk_in);
        eaddr <= 4'h3;
        ewdata <= 8'hA5;
        ewr <= 1'b1;
        @(posedge sys_clk_in);
        ewr <= 1'b0;
        wreg(scmc_pkg::OFF_PROG, 8'h21);
        rreg("volt on", scmc_pkg::OFF_PROG, 8'hFF, 8'h21);
        chk("volt pin", {7'h00, volt}, 8'h01);
        repeat (8) @(posedge sys_clk_in);
        wreg(scmc_pkg::OFF_PROG, 8'h00);
        rreg("prog clear", scmc_pkg::OFF_PROG, 8'hFF, 8'h00);
        rep("programmed", 4'h3, 8'hA5);
        rep("erased", 4'h4, 8'hFF);
        $display("test eprom done");
        complete_run();
    end
endmodule
`default_nettype wire
